/* rtl/prs_map.svh */
// Constants of the power reset sequencer: timing, masks and bit positions
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH

// ============================================================
// Clock and timing figures
`define PRS_CLK_KHZ 125000
`define PRS_RESET_HOLD_MS 50
`define PRS_SEQ_STEP_US 500
`define PRS_HOST_REL_WAIT_MS 10
`define PRS_HOST_SYS_WAIT_MS 125
`define PRS_HOST_CORE_WAIT_MS 125

// ============================================================
// Thermal comparators
`define PRS_NUM_COMP 6
`define PRS_COMP_HYST_LO 0
`define PRS_COMP_HYST_HI 1
`define PRS_ALWAYS_ON_MASK 6'h03
`define PRS_ALL_COMP_MASK 6'h3F

// ============================================================
// Power-good bit positions and reset values
`define PRS_PG_FIRST 0
`define PRS_PG_HV 1
`define PRS_PG_LV 2
`define PRS_PG_ALL 3'h7
`define PRS_DELAY_NONE 2'h0
`define PRS_LEVEL_RESET 3'h0

`endif

/* rtl/prs_pkg.sv */
// Types of the power reset sequencer
package prs_pkg;

  // Supply sequencer states, Gray along OFF-UP-ON-DOWN
  typedef enum logic [1:0] {
    SEQ_OFF = 2'h0,
    SEQ_UP_WAIT = 2'h1,
    SEQ_ON = 2'h3,
    SEQ_DOWN_WAIT = 2'h2
  } prs_seq_state_t;

  // Host start-up states, Gray along the boot path
  typedef enum logic [2:0] {
    HST_WAIT_REL = 3'h0,
    HST_PRE_SYS = 3'h1,
    HST_SYS_ON = 3'h3,
    HST_CORE_ON = 3'h2,
    HST_RUN = 3'h6,
    HST_FAIL = 3'h7
  } prs_host_state_t;

endpackage

/* rtl/prs_link_if.sv */
// Link between the sequencer device and the application processor
interface prs_link_if;
  // Device to processor
  logic resetOutN;
  logic mainBatteryFaultN;
  logic wakeup;
  logic [2:0] powerGood;
  // Processor to device
  logic resetInN;
  logic systemSupplyEnable;
  logic coreSupplyEnable;

  modport dev (
    output resetOutN,
    output mainBatteryFaultN,
    output wakeup,
    output powerGood,
    input resetInN,
    input systemSupplyEnable,
    input coreSupplyEnable
  );

  modport host (
    input resetOutN,
    input mainBatteryFaultN,
    input wakeup,
    input powerGood,
    output resetInN,
    output systemSupplyEnable,
    output coreSupplyEnable
  );
endinterface

/* rtl/prs_device.sv */
// Power reset sequencer, device end: reset, supplies and thermal flags
//
// Operation
// - All-flags bit powers all six comparators
// - Software sets all-flags only while reading level
// - Three-bit binary temperature level in status
// - Two comparators always on for warning
// - Thermal warning drives the wakeup output
// - Reset output held low until always-on stable
// - Reset held at least 50 ms after supply
// - Battery fault released once main power present
// - Processor enables system after both releases
// - Processor waits about 10 ms first
// - First group on, others after delay
// - Processor waits 125 ms before core enable
// - Core enable switches low-voltage regulators on
// - Processor checks power-good 125 ms later
// - Reset input low forces 50 ms reset
// - Release no sooner than 50 ms, repeat
// - Delay field selects 0, 0.5, 1, 1.5 ms
// - First group switches off last
// - Core needs system enable unless bypassed
// - Per-domain read-only power-good bits
`include "prs_map.svh"

module prs_device #(
  parameter int unsigned RESET_HOLD_CYC = `PRS_RESET_HOLD_MS * `PRS_CLK_KHZ,
  parameter int unsigned SEQ_STEP_CYC = `PRS_SEQ_STEP_US * `PRS_CLK_KHZ / 1000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link to the processor
  prs_link_if.dev link,
  // Analog status inputs, asynchronous
  input wire logic alwaysOnStable,
  input wire logic mainPowerPresent,
  input wire logic [`PRS_NUM_COMP-1:0] tempFlags,
  input wire logic [2:0] regSettled,
  // Control bits
  input wire logic allFlagsEnable,
  input wire logic bypassSystemDependency,
  input wire logic [1:0] seqDelaySel,
  input wire logic sysEnReg,
  input wire logic coreEnReg,
  // Regulator and comparator controls
  output logic [`PRS_NUM_COMP-1:0] compEnable,
  output logic firstRegulatorGroupEn,
  output logic hvSupplyEn,
  output logic lvSupplyEn,
  // Status
  output logic [2:0] tempLevel,
  output logic thermalWarning,
  output logic [2:0] powerGood
);

  // ============================================================
  // Input synchronisers
  localparam int unsigned NUM_ASYNC = `PRS_NUM_COMP + 5;
  logic [NUM_ASYNC-1:0] asyncIn;
  logic [NUM_ASYNC-1:0] syncIn;
  logic [`PRS_NUM_COMP-1:0] flagsSync;
  logic [2:0] settledSync;
  logic aonStableSync;
  logic mainPowerSync;
  assign asyncIn = {regSettled, tempFlags, mainPowerPresent, alwaysOnStable};
  assign aonStableSync = syncIn[0];
  assign mainPowerSync = syncIn[1];
  assign flagsSync = syncIn[`PRS_NUM_COMP+1:2];
  assign settledSync = syncIn[NUM_ASYNC-1:`PRS_NUM_COMP+2];
  // Three stages; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ASYNC; gi++)
    begin : g_sync
      logic s1Reg;
      logic s2Reg;
      logic s3Reg;
      logic filtReg;
      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          {s1Reg, s2Reg, s3Reg, filtReg} <= 4'h0;
        else
        begin
          s1Reg <= asyncIn[gi];
          s2Reg <= s1Reg;
          s3Reg <= s2Reg;
          if (s2Reg == s3Reg)
            filtReg <= s3Reg;
        end
      end
      assign syncIn[gi] = filtReg;
    end
  endgenerate

  // ============================================================
  // Supply enables, pin or control bit
  logic sysActive;
  logic coreActive;
  assign sysActive = link.systemSupplyEnable | sysEnReg;
  assign coreActive = link.coreSupplyEnable | coreEnReg;

  // ============================================================
  // Processor reset output and battery fault
  logic resetOutReg;
  logic [31:0] holdCnt;
  logic battFaultReg;
  // Hold reset low; count only with stable supply and no reset request
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resetOutReg <= 1'b0;
      holdCnt <= 32'h0000_0000;
    end
    else if (!aonStableSync || !link.resetInN)
    begin
      resetOutReg <= 1'b0;
      holdCnt <= 32'h0000_0000;
    end
    else if (!resetOutReg)
    begin
      if (holdCnt == RESET_HOLD_CYC - 1)
        resetOutReg <= 1'b1;
      else
        holdCnt <= holdCnt + 32'h0000_0001;
    end
  end
  // Battery fault released while main power is present
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      battFaultReg <= 1'b0;
    else
      battFaultReg <= mainPowerSync;
  end

  assign link.resetOutN = resetOutReg;
  assign link.mainBatteryFaultN = battFaultReg;

  // ============================================================
  // System supply sequencer
  prs_pkg::prs_seq_state_t seqState;
  logic [31:0] seqCnt;
  logic [31:0] seqLoad;
  // Gap after the first group, in half-millisecond steps
  assign seqLoad = 32'(32'(seqDelaySel) * SEQ_STEP_CYC - 1);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seqState <= prs_pkg::SEQ_OFF;
      seqCnt <= 32'h0000_0000;
    end
    else
    begin
      unique case (seqState)
        prs_pkg::SEQ_OFF:
        begin
          if (sysActive)
          begin
            seqCnt <= seqLoad;
            if (seqDelaySel == `PRS_DELAY_NONE)
              seqState <= prs_pkg::SEQ_ON;
            else
              seqState <= prs_pkg::SEQ_UP_WAIT;
          end
        end
        prs_pkg::SEQ_UP_WAIT:
        begin
          if (!sysActive)
          begin
            seqCnt <= seqLoad;
            seqState <= prs_pkg::SEQ_DOWN_WAIT;
          end
          else if (seqCnt == 32'h0000_0000)
            seqState <= prs_pkg::SEQ_ON;
          else
            seqCnt <= seqCnt - 32'h0000_0001;
        end
        prs_pkg::SEQ_ON:
        begin
          if (!sysActive)
          begin
            seqCnt <= seqLoad;
            if (seqDelaySel == `PRS_DELAY_NONE)
              seqState <= prs_pkg::SEQ_OFF;
            else
              seqState <= prs_pkg::SEQ_DOWN_WAIT;
          end
        end
        prs_pkg::SEQ_DOWN_WAIT:
        begin
          if (seqCnt == 32'h0000_0000)
            seqState <= prs_pkg::SEQ_OFF;
          else
            seqCnt <= seqCnt - 32'h0000_0001;
        end
      endcase
    end
  end

  // First group leads on the way up and trails on the way down
  assign firstRegulatorGroupEn = (seqState != prs_pkg::SEQ_OFF);
  assign hvSupplyEn = (seqState == prs_pkg::SEQ_ON);

  // Low-voltage regulators follow the core enable
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      lvSupplyEn <= 1'b0;
    else
      lvSupplyEn <= coreActive &
        (bypassSystemDependency | sysActive);
  end

  // Power-good only once a settled regulator is enabled
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      powerGood <= 3'h0;
    else
    begin
      powerGood[`PRS_PG_FIRST] <=
        firstRegulatorGroupEn & settledSync[`PRS_PG_FIRST];
      powerGood[`PRS_PG_HV] <= hvSupplyEn & settledSync[`PRS_PG_HV];
      powerGood[`PRS_PG_LV] <= lvSupplyEn & settledSync[`PRS_PG_LV];
    end
  end

  assign link.powerGood = powerGood;

  // ============================================================
  // Thermal flags
  logic [`PRS_NUM_COMP-1:0] flagsValid;
  logic [2:0] levelNext;
  // Warning pair always powered, the rest only on request
  assign compEnable = allFlagsEnable ? `PRS_ALL_COMP_MASK
                                     : `PRS_ALWAYS_ON_MASK;
  assign flagsValid = flagsSync & compEnable;
  // Level is the count of tripped comparators in the thermometer
  always_comb
  begin
    levelNext = `PRS_LEVEL_RESET;
    for (int i = 0; i < `PRS_NUM_COMP; i++)
      levelNext = levelNext + 3'(flagsValid[i]);
  end
  // Level shown only while all comparators are powered
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      tempLevel <= `PRS_LEVEL_RESET;
    else if (allFlagsEnable)
      tempLevel <= levelNext;
    else
      tempLevel <= `PRS_LEVEL_RESET;
  end
  // Warning sets at the high comparator, clears below the low one
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      thermalWarning <= 1'b0;
    else if (flagsSync[`PRS_COMP_HYST_HI])
      thermalWarning <= 1'b1;
    else if (!flagsSync[`PRS_COMP_HYST_LO])
      thermalWarning <= 1'b0;
  end
  assign link.wakeup = thermalWarning;

endmodule

/* rtl/prs_host.sv */
// Power reset sequencer, processor end: boot handshake with the device
`include "prs_map.svh"

module prs_host #(
  parameter int unsigned REL_WAIT_CYC =
    `PRS_HOST_REL_WAIT_MS * `PRS_CLK_KHZ,
  parameter int unsigned SYS_WAIT_CYC =
    `PRS_HOST_SYS_WAIT_MS * `PRS_CLK_KHZ,
  parameter int unsigned CORE_WAIT_CYC =
    `PRS_HOST_CORE_WAIT_MS * `PRS_CLK_KHZ
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link to the device
  prs_link_if.host link,
  // User side
  input wire logic hwResetReq,
  input wire logic allFlagsReadReq,
  output logic allFlagsEnable,
  output logic bootDone,
  output logic bootFail,
  output logic thermalAlert
);

  // ============================================================
  // Boot sequence
  prs_pkg::prs_host_state_t state;
  logic [31:0] waitCnt;
  logic released;
  logic resetInReg;

  // Both releases needed, in either order
  assign released = link.resetOutN & link.mainBatteryFaultN;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= prs_pkg::HST_WAIT_REL;
      waitCnt <= 32'h0000_0000;
    end
    else if (!released)
    begin
      state <= prs_pkg::HST_WAIT_REL;
      waitCnt <= 32'h0000_0000;
    end
    else
    begin
      unique case (state)
        prs_pkg::HST_WAIT_REL:
        begin
          waitCnt <= 32'(REL_WAIT_CYC - 1);
          state <= prs_pkg::HST_PRE_SYS;
        end
        prs_pkg::HST_PRE_SYS:
        begin
          if (waitCnt == 32'h0000_0000)
          begin
            waitCnt <= 32'(SYS_WAIT_CYC - 1);
            state <= prs_pkg::HST_SYS_ON;
          end
          else
            waitCnt <= waitCnt - 32'h0000_0001;
        end
        prs_pkg::HST_SYS_ON:
        begin
          if (waitCnt == 32'h0000_0000)
          begin
            waitCnt <= 32'(CORE_WAIT_CYC - 1);
            state <= prs_pkg::HST_CORE_ON;
          end
          else
            waitCnt <= waitCnt - 32'h0000_0001;
        end
        prs_pkg::HST_CORE_ON:
        begin
          if (waitCnt != 32'h0000_0000)
            waitCnt <= waitCnt - 32'h0000_0001;
          else if (link.powerGood == `PRS_PG_ALL)
            state <= prs_pkg::HST_RUN;
          else
            state <= prs_pkg::HST_FAIL;
        end
        prs_pkg::HST_RUN:
          state <= prs_pkg::HST_RUN;
        prs_pkg::HST_FAIL:
          state <= prs_pkg::HST_FAIL;
        default:
          state <= prs_pkg::HST_WAIT_REL;
      endcase
    end
  end

  // Enables follow the state; all drop when the device resets
  assign link.systemSupplyEnable = (state == prs_pkg::HST_SYS_ON) |
    (state == prs_pkg::HST_CORE_ON) | (state == prs_pkg::HST_RUN);
  assign link.coreSupplyEnable = (state == prs_pkg::HST_CORE_ON) |
    (state == prs_pkg::HST_RUN);
  assign bootDone = (state == prs_pkg::HST_RUN);
  assign bootFail = (state == prs_pkg::HST_FAIL);

  // Hardware reset request drives the reset input low
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resetInReg <= 1'b1;
      allFlagsEnable <= 1'b0;
    end
    else
    begin
      resetInReg <= !hwResetReq;
      allFlagsEnable <= allFlagsReadReq;
    end
  end

  assign link.resetInN = resetInReg;
  assign thermalAlert = link.wakeup;

endmodule

/* test/prs_link_checker.sv */
// Checker of the link between the sequencer device and the processor
module prs_link_checker #(
  parameter int unsigned RESET_HOLD_CYC = 20,
  parameter int unsigned REL_WAIT_CYC = 10,
  parameter int unsigned SYS_WAIT_CYC = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link signals
  input wire logic resetOutN,
  input wire logic mainBatteryFaultN,
  input wire logic wakeup,
  input wire logic [2:0] powerGood,
  input wire logic resetInN,
  input wire logic systemSupplyEnable,
  input wire logic coreSupplyEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned inHighReg;
  int unsigned relReg;
  int unsigned sysReg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ============================================================
  // Helper counters
  // Cycles each condition has held without a break
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inHighReg <= 0;
      relReg <= 0;
      sysReg <= 0;
    end
    else
    begin
      inHighReg <= resetInN ? inHighReg + 1 : 0;
      relReg <= (resetOutN && mainBatteryFaultN) ? relReg + 1 : 0;
      sysReg <= systemSupplyEnable ? sysReg + 1 : 0;
    end
  end

  // ============================================================
  // Assertions
  AST_RESET_FOLLOWS:
    assert property (!resetInN |=> !resetOutN)
    else $error("reset output not low after reset input");
  AST_HOLD_MIN:
    assert property ($rose(resetOutN) |-> inHighReg >= RESET_HOLD_CYC)
    else $error("reset output released too early");
  AST_SYS_NEEDS_REL:
    assert property ($rose(systemSupplyEnable)
      |-> resetOutN && mainBatteryFaultN)
    else $error("system enable before both releases");
  AST_LOSS_DROPS:
    assert property (!(resetOutN && mainBatteryFaultN)
      |=> !systemSupplyEnable && !coreSupplyEnable)
    else $error("enables kept after release lost");
  AST_REL_WAIT:
    assert property ($rose(systemSupplyEnable) |-> relReg >= REL_WAIT_CYC)
    else $error("system enable too soon after release");
  AST_CORE_WAIT:
    assert property ($rose(coreSupplyEnable)
      |-> systemSupplyEnable && sysReg >= SYS_WAIT_CYC)
    else $error("core enable too soon after system enable");
  AST_LV_DROP:
    assert property ($fell(coreSupplyEnable) |-> ##2 !powerGood[2])
    else $error("low-voltage good kept after core enable off");
  AST_HV_DROP:
    assert property ($fell(systemSupplyEnable) |-> ##2 !powerGood[1])
    else $error("high-voltage good kept after system enable off");
  AST_FIRST_LAST:
    assert property (powerGood[1] |-> powerGood[0])
    else $error("high-voltage good without first group good");

  // Main scenarios reached
  cover property ($rose(resetOutN));
  cover property ($rose(coreSupplyEnable));
  cover property ($rose(wakeup));
endmodule

/* test/pmu_reset_power_sequencer_tb.sv */
// Bench of the power reset sequencer with both ends joined
module pmu_reset_power_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam int STEP = 4;
  localparam int REL = 10;
  localparam int SYSW = 20;
  logic clk_sys = 1'b0;
  logic arst_n;
  logic alwaysOnStable, mainPowerPresent, bypass, sysEnReg, coreEnReg;
  logic hwResetReq, allFlagsReadReq, flagsEn, bootDone, bootFail;
  logic thermalAlert, firstEn, hvEn, lvEn, thermalWarning;
  logic [5:0] tempFlags, compEnable;
  logic [2:0] regSettled, tempLevel, devPowerGood;
  logic [1:0] seqDelaySel;
  int fails = 0;
  int cmpCount = 0;
  int n, m;
  time t0;

  prs_link_if prs_link_if_i ();

  // Device end
  prs_device #(.RESET_HOLD_CYC(HOLD), .SEQ_STEP_CYC(STEP)) prs_device_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .link(prs_link_if_i),
    .alwaysOnStable(alwaysOnStable), .mainPowerPresent(mainPowerPresent),
    .tempFlags(tempFlags), .regSettled(regSettled),
    .allFlagsEnable(flagsEn), .bypassSystemDependency(bypass),
    .seqDelaySel(seqDelaySel), .sysEnReg(sysEnReg), .coreEnReg(coreEnReg),
    .compEnable(compEnable), .firstRegulatorGroupEn(firstEn),
    .hvSupplyEn(hvEn), .lvSupplyEn(lvEn), .tempLevel(tempLevel),
    .thermalWarning(thermalWarning), .powerGood(devPowerGood));

  // Processor end
  prs_host #(.REL_WAIT_CYC(REL), .SYS_WAIT_CYC(SYSW), .CORE_WAIT_CYC(30))
  prs_host_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .link(prs_link_if_i),
    .hwResetReq(hwResetReq), .allFlagsReadReq(allFlagsReadReq),
    .allFlagsEnable(flagsEn), .bootDone(bootDone), .bootFail(bootFail),
    .thermalAlert(thermalAlert));

  // Link checker
  prs_link_checker #(.RESET_HOLD_CYC(HOLD), .REL_WAIT_CYC(REL),
    .SYS_WAIT_CYC(SYSW)) prs_link_checker_i (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .resetOutN(prs_link_if_i.resetOutN),
    .mainBatteryFaultN(prs_link_if_i.mainBatteryFaultN),
    .wakeup(prs_link_if_i.wakeup), .powerGood(prs_link_if_i.powerGood),
    .resetInN(prs_link_if_i.resetInN),
    .systemSupplyEnable(prs_link_if_i.systemSupplyEnable),
    .coreSupplyEnable(prs_link_if_i.coreSupplyEnable));

  // Clock of 8 ns
  always #4 clk_sys = ~clk_sys;

  // ============================================================
  // Shared tasks
  task tick;
    @(posedge clk_sys);
    #1;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task test_done;
    if (fails == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task t_cold;
    repeat (HOLD + 5) tick;
    chk(8'(prs_link_if_i.resetOutN), 8'h00);
    alwaysOnStable = 1'b1;
    for (n = 0; !prs_link_if_i.resetOutN && n < 500; n++) tick;
    chk(8'(n >= HOLD), 8'h01);
    repeat (REL + 5) tick;
    chk(8'(prs_link_if_i.systemSupplyEnable), 8'h00);
    mainPowerPresent = 1'b1;
    repeat (6) tick;
    chk(8'(prs_link_if_i.mainBatteryFaultN), 8'h01);
    for (n = 0; !bootDone && n < 500; n++) tick;
    chk(8'({bootDone, bootFail}), 8'h02);
    chk(8'({firstEn, hvEn, lvEn}), 8'h07);
  endtask

  task t_settle;
    regSettled = 3'h0;
    repeat (6) tick;
    chk(8'(prs_link_if_i.powerGood), 8'h00);
    regSettled = 3'h7;
    repeat (6) tick;
    chk(8'(devPowerGood), 8'h07);
  endtask

  task t_thermal;
    chk(8'(compEnable), 8'h03);
    tempFlags = 6'h03;
    repeat (7) tick;
    chk(8'({prs_link_if_i.wakeup, thermalAlert}), 8'h03);
    tempFlags = 6'h01;
    repeat (7) tick;
    chk(8'(prs_link_if_i.wakeup), 8'h01);
    tempFlags = 6'h00;
    repeat (7) tick;
    chk(8'(thermalWarning), 8'h00);
    allFlagsReadReq = 1'b1;
    repeat (2) tick;
    chk(8'(compEnable), 8'h3F);
    for (int k = 0; k <= 6; k++)
    begin
      tempFlags = 6'((1 << k) - 1);
      repeat (7) tick;
      chk(8'(tempLevel), 8'(k));
    end
    tempFlags = 6'h00;
    allFlagsReadReq = 1'b0;
    repeat (7) tick;
    chk(8'({compEnable, tempLevel}), 8'h18);
  endtask

  task t_bypass;
    hwResetReq = 1'b1;
    repeat (30) tick;
    chk(8'(prs_link_if_i.resetOutN), 8'h00);
    coreEnReg = 1'b1;
    repeat (3) tick;
    chk(8'(lvEn), 8'h00);
    bypass = 1'b1;
    repeat (3) tick;
    chk(8'(lvEn), 8'h01);
    sysEnReg = 1'b1;
    repeat (3) tick;
    chk(8'(firstEn), 8'h01);
    coreEnReg = 1'b0;
    bypass = 1'b0;
    sysEnReg = 1'b0;
    repeat (20) tick;
    hwResetReq = 1'b0;
  endtask

  task t_delay(input int sel);
    seqDelaySel = 2'(sel);
    for (n = 0; !hvEn && n < 500; n++) tick;
    hwResetReq = 1'b1;
    tick;
    hwResetReq = 1'b0;
    t0 = $time;
    for (n = 0; hvEn && n < 50; n++) tick;
    for (m = 0; firstEn && m < 50; m++) tick;
    chk(8'(m), 8'(sel * STEP));
    chk(8'(prs_link_if_i.resetOutN), 8'h00);
    for (n = 0; !prs_link_if_i.resetOutN && n < 500; n++) tick;
    chk(8'(($time - t0) >= HOLD * 8), 8'h01);
    for (n = 0; !firstEn && n < 500; n++) tick;
    for (m = 0; !hvEn && m < 50; m++) tick;
    chk(8'(m), 8'(sel * STEP));
  endtask

  task t_fail;
    for (n = 0; !bootDone && n < 500; n++) tick;
    chk(8'(bootDone), 8'h01);
    regSettled = 3'h3;
    hwResetReq = 1'b1;
    tick;
    hwResetReq = 1'b0;
    for (n = 0; !bootFail && n < 500; n++) tick;
    chk(8'({bootDone, bootFail}), 8'h01);
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    {alwaysOnStable, mainPowerPresent, bypass, sysEnReg} = 4'h0;
    {coreEnReg, hwResetReq, allFlagsReadReq} = 3'h0;
    tempFlags = 6'h00;
    regSettled = 3'h7;
    seqDelaySel = 2'h0;
    repeat (10) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    t_cold();
    t_settle();
    t_thermal();
    t_bypass();
    for (int s = 0; s < 4; s++)
      t_delay(s);
    t_fail();
    test_done();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end
endmodule
